// [hw/pacsr_pkg.sv]
// Constants, field positions and types for the auxiliary control and status register
package pacsr_pkg;

   // ****************************************************************
   // Register location and field positions
   // ****************************************************************
   localparam logic [4:0] PACSR_REG_ADDR   = 5'h1c;
   localparam int         PACSR_BIT_AN_DONE = 15;
   localparam int         PACSR_BIT_AN_BYP  = 14;
   localparam int         PACSR_BIT_XOVER   = 13;
   localparam int         PACSR_BIT_CD_SWAP = 12;
   localparam int         PACSR_BIT_POL_HI  = 11;
   localparam int         PACSR_BIT_POL_LO  = 8;
   localparam int         PACSR_BIT_DUPLEX  = 5;
   localparam int         PACSR_BIT_SPD_HI  = 4;
   localparam int         PACSR_BIT_SPD_LO  = 3;
   localparam int         PACSR_BIT_PRIO    = 2;
   localparam int         PACSR_BIT_STICKY  = 1;

   // ****************************************************************
   // Speed codes and reset values
   // ****************************************************************
   localparam logic [1:0] PACSR_SPD_10     = 2'h0;
   localparam logic [1:0] PACSR_SPD_100    = 2'h1;
   localparam logic [1:0] PACSR_SPD_1000   = 2'h2;
   localparam logic       PACSR_PRIO_RST   = 1'b0;
   localparam logic       PACSR_STICKY_RST = 1'b0;

   // ****************************************************************
   // Management frame layout
   // ****************************************************************
   localparam logic [1:0] PACSR_OP_RD    = 2'h2;
   localparam logic [1:0] PACSR_OP_WR    = 2'h1;
   localparam int         PACSR_PRE_LEN  = 32;
   localparam logic [5:0] PACSR_HDR_LAST = 6'h0c;
   localparam logic [5:0] PACSR_DATA_LEN = 6'h10;
   localparam logic [5:0] PACSR_WR_LAST  = 6'h11;
   localparam logic [5:0] PACSR_ONES_MAX = 6'h3f;

   // Serial frame sequencer states
   typedef enum logic [2:0] {
      SM_PRE,
      SM_HDR,
      SM_TA,
      SM_RD,
      SM_WR
   } pacsr_state_e;

   // Whole state of the block
   typedef struct packed {
      logic         mdc_s1;
      logic         mdc_s2;
      logic         mdc_s3;
      logic         mdio_s1;
      logic         mdio_s2;
      logic [4:0]   strap_s1;
      logic [4:0]   strap_s2;
      pacsr_state_e state;
      logic [5:0]   cnt;
      logic [5:0]   ones;
      logic [15:0]  sh;
      logic         mdio_o;
      logic         mdio_oe;
      logic         prio;
      logic         sticky;
      logic         swap_cd_en;
      logic [3:0]   pol_correct;
      logic         mdix_internal;
      logic         strap_override;
      logic         mode_aneg_disable;
      logic         mode_force_duplex;
      logic [2:0]   mode_speed_en;
   } pacsr_reg_s;

endpackage

// [hw/pacsr_aux_reg.sv]
// Auxiliary control and status register with its serial management slave
`timescale 1ns/1ps
module pacsr_aux_reg
   import pacsr_pkg::*;
#(
   parameter int PRE_LEN = PACSR_PRE_LEN
) (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   // Management pins
   input  wire logic       mdc,
   input  wire logic       mdio_i,
   output logic            mdio_o,
   output logic            mdio_oe,
   input  wire logic [4:0] phy_addr,
   // Status from the rest of the transceiver
   input  wire logic       an_complete,
   input  wire logic       an_enable,
   input  wire logic       scr_lock,
   input  wire logic       xover_det,
   input  wire logic       cd_swap_det,
   input  wire logic [3:0] pol_det,
   input  wire logic       res_duplex,
   input  wire logic [1:0] res_speed,
   input  wire logic       pair_swap_dis,
   input  wire logic       pol_corr_dis,
   input  wire logic       mii_soft_reset,
   // Capability settings held in other management registers
   input  wire logic       mii_force_duplex,
   input  wire logic [2:0] mii_speed_en,
   // Configuration straps
   input  wire logic       strap_speed_low,
   input  wire logic       strap_speed_mid,
   input  wire logic       strap_speed_gig,
   input  wire logic       strap_force_duplex,
   input  wire logic       strap_negotiation_disable,
   // Controls to the data path
   output logic            swap_cd_en,
   output logic [3:0]      pol_correct,
   output logic            mdix_internal,
   output logic            strap_override,
   output logic            mode_aneg_disable,
   output logic            mode_force_duplex,
   output logic [2:0]      mode_speed_en
);

   // A preamble counter of six bits cannot count beyond 63, so refuse it while elaborating
   if (PRE_LEN < 1 || PRE_LEN > 63) begin : g_pre_len_bad
      $error("PRE_LEN out of range");
   end

   // ****************************************************************
   // Status word as seen by a reader
   // ****************************************************************
   localparam logic [5:0] PRE_CNT = 6'(PRE_LEN);

   pacsr_reg_s  st;
   pacsr_reg_s  next_st;
   logic        mdc_rise;
   logic        gig_mode;
   logic        xover_ok;
   logic [15:0] read_word;
   logic        wr_commit;
   logic [15:0] wr_word;
   logic        all_ones;

   assign mdc_rise = st.mdc_s2 && !st.mdc_s3;
   assign gig_mode = (res_speed == PACSR_SPD_1000);
   assign xover_ok = xover_det && scr_lock;
   assign all_ones = &st.strap_s2;

   // Unspecified bits stay zero, which also holds the reserved fields
   always_comb begin
      read_word = 16'h0000;
      read_word[PACSR_BIT_AN_DONE] = an_complete;
      read_word[PACSR_BIT_AN_BYP] = !an_enable;
      read_word[PACSR_BIT_XOVER] = xover_ok;
      read_word[PACSR_BIT_CD_SWAP] = cd_swap_det && gig_mode;
      // Polarity flags are hidden until negotiation ends
      read_word[PACSR_BIT_POL_HI:PACSR_BIT_POL_LO] = an_complete ? pol_det : 4'h0;
      read_word[PACSR_BIT_DUPLEX] = res_duplex;
      read_word[PACSR_BIT_SPD_HI:PACSR_BIT_SPD_LO] = res_speed;
      read_word[PACSR_BIT_PRIO] = st.prio;
      read_word[PACSR_BIT_STICKY] = st.sticky;
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   // MDC is slow against sys_clk, so one sample per rising edge suffices
   always_comb begin
      next_st = st;
      wr_commit = 1'b0;
      wr_word = {st.sh[14:0], st.mdio_s2};
      next_st.mdc_s1 = mdc;
      next_st.mdc_s2 = st.mdc_s1;
      next_st.mdc_s3 = st.mdc_s2;
      next_st.mdio_s1 = mdio_i;
      next_st.mdio_s2 = st.mdio_s1;
      next_st.strap_s1 = {strap_negotiation_disable, strap_force_duplex,
                          strap_speed_gig, strap_speed_mid, strap_speed_low};
      next_st.strap_s2 = st.strap_s1;
      if (mdc_rise) begin
         case (st.state)
            SM_PRE: begin
               if (st.mdio_s2) begin
                  if (st.ones != PACSR_ONES_MAX) begin
                     next_st.ones = st.ones + 6'h01;
                  end
               end else begin
                  next_st.ones = 6'h00;
                  if (st.ones >= PRE_CNT) begin
                     next_st.state = SM_HDR;
                     next_st.cnt = 6'h00;
                  end
               end
            end
            SM_HDR: begin
               next_st.sh = wr_word;
               next_st.cnt = st.cnt + 6'h01;
               if (st.cnt == PACSR_HDR_LAST) begin
                  next_st.state = SM_PRE;
                  next_st.ones = 6'h00;
                  // Start bit, own address and this register must all match
                  if (wr_word[12] && wr_word[9:5] == phy_addr
                      && wr_word[4:0] == PACSR_REG_ADDR) begin
                     if (wr_word[11:10] == PACSR_OP_RD) begin
                        next_st.state = SM_TA;
                     end else if (wr_word[11:10] == PACSR_OP_WR) begin
                        next_st.state = SM_WR;
                        next_st.cnt = 6'h00;
                     end
                  end
               end
            end
            SM_TA: begin
               // Second turnaround bit is driven low by this end
               next_st.mdio_oe = 1'b1;
               next_st.mdio_o = 1'b0;
               next_st.sh = read_word;
               next_st.cnt = 6'h00;
               next_st.state = SM_RD;
            end
            SM_RD: begin
               if (st.cnt == PACSR_DATA_LEN) begin
                  next_st.mdio_oe = 1'b0;
                  next_st.mdio_o = 1'b0;
                  next_st.state = SM_PRE;
                  next_st.ones = 6'h00;
               end else begin
                  next_st.mdio_o = st.sh[15];
                  next_st.sh = {st.sh[14:0], 1'b0};
                  next_st.cnt = st.cnt + 6'h01;
               end
            end
            SM_WR: begin
               next_st.sh = wr_word;
               next_st.cnt = st.cnt + 6'h01;
               if (st.cnt == PACSR_WR_LAST) begin
                  wr_commit = 1'b1;
                  next_st.state = SM_PRE;
                  next_st.ones = 6'h00;
               end
            end
            default: begin
               next_st.state = SM_PRE;
            end
         endcase
      end
      // Status fields ignore writes; only the two controls take data
      if (wr_commit) begin
         next_st.prio = wr_word[PACSR_BIT_PRIO];
         next_st.sticky = wr_word[PACSR_BIT_STICKY];
      end
      // Unless sticky is already set, soft reset outranks a write landing in the same cycle
      if (mii_soft_reset && !st.sticky) begin
         next_st.prio = PACSR_PRIO_RST;
         next_st.sticky = PACSR_STICKY_RST;
      end
      // Data path controls
      next_st.swap_cd_en = cd_swap_det && gig_mode && !pair_swap_dis;
      next_st.pol_correct = pol_det & {4{!pol_corr_dis}};
      next_st.mdix_internal = xover_ok;
      // Operating mode selection; capability registers are only read here
      next_st.strap_override = !st.prio && !all_ones;
      if (next_st.strap_override) begin
         next_st.mode_aneg_disable = st.strap_s2[4];
         next_st.mode_force_duplex = st.strap_s2[3];
         next_st.mode_speed_en = st.strap_s2[2:0];
      end else begin
         next_st.mode_aneg_disable = !an_enable;
         next_st.mode_force_duplex = mii_force_duplex;
         next_st.mode_speed_en = mii_speed_en;
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         st <= '0;
         st.state <= SM_PRE;
         st.prio <= PACSR_PRIO_RST;
         st.sticky <= PACSR_STICKY_RST;
      end else begin
         st <= next_st;
      end
   end

   assign mdio_o = st.mdio_o;
   assign mdio_oe = st.mdio_oe;
   assign swap_cd_en = st.swap_cd_en;
   assign pol_correct = st.pol_correct;
   assign mdix_internal = st.mdix_internal;
   assign strap_override = st.strap_override;
   assign mode_aneg_disable = st.mode_aneg_disable;
   assign mode_force_duplex = st.mode_force_duplex;
   assign mode_speed_en = st.mode_speed_en;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);

   sequence s_ta_edge;
      st.state == SM_TA && mdc_rise;
   endsequence

   sequence s_turn_drive;
      mdio_oe && !mdio_o && st.state == SM_RD;
   endsequence

   a_read_turn: assert property (s_ta_edge |=> s_turn_drive ##0 st.sh == $past(read_word))
      else $error("turnaround or read data capture wrong");

   a_an_mirror: assert property (st.state == SM_TA |-> read_word[15] == an_complete)
      else $error("bit 15 does not mirror negotiation complete");

   a_an_bypass: assert property (an_enable |-> !read_word[14])
      else $error("bypass flag set while negotiation enabled");

   a_xover_lock: assert property (!scr_lock |=> !mdix_internal)
      else $error("crossover acted on before descrambler lock");

   a_cd_swap: assert property (1'b1 |=> swap_cd_en
                               == $past(cd_swap_det && gig_mode && !pair_swap_dis))
      else $error("pair swap control wrong");

   a_cd_gig_only: assert property (!gig_mode |-> !read_word[12])
      else $error("pair swap flag shown outside gigabit");

   a_pol_corr: assert property (pol_corr_dis |=> pol_correct == 4'h0)
      else $error("polarity corrected while disabled");

   a_pol_valid: assert property (!an_complete |-> read_word[11:8] == 4'h0)
      else $error("polarity flags shown before negotiation complete");

   a_speed_dup: assert property (read_word[5:3] == {res_duplex, res_speed})
      else $error("speed or duplex field wrong");

   // Mode follows the straps sampled in the cycle that decided the override
   a_strap_win: assert property (!st.prio && !all_ones |=> strap_override
                                 && {mode_aneg_disable, mode_force_duplex, mode_speed_en}
                                    == $past(st.strap_s2))
      else $error("straps failed to override");

   a_reg_win: assert property (st.prio |=> !strap_override)
      else $error("straps override while registers have priority");

   a_prio_hold: assert property (!st.prio && !wr_commit |=> !st.prio)
      else $error("priority bit set without a write");

   a_soft_clear: assert property (mii_soft_reset && !st.sticky
                                  |=> !st.prio && !st.sticky)
      else $error("soft reset failed to clear sticky bits");

   a_soft_keep: assert property (mii_soft_reset && st.sticky && !wr_commit
                                 |=> $stable(st.prio) && st.sticky)
      else $error("soft reset disturbed kept sticky bits");

   a_reserved: assert property (read_word[7:6] == 2'h0 && !read_word[0])
      else $error("reserved bits read nonzero");

   a_write_take: assert property (wr_commit && !mii_soft_reset
                                  |=> st.prio == $past(wr_word[2])
                                      && st.sticky == $past(wr_word[1]))
      else $error("write to control bits not taken");

endmodule

// [dv/pacsr_smi_master.sv]
// Management station model that drives serial frames into the register block
`timescale 1ns/1ps
module pacsr_smi_master
   import pacsr_pkg::*;
(
   // Clock
   input  wire logic sys_clk,
   // Management pins
   output logic      mdc,
   output logic      mdio_m,
   output logic      mdio_m_oe,
   input  wire logic mdio
);
   // Management clock stands still low between frames
   initial begin
      mdc = 1'b0;
      mdio_m = 1'b1;
      mdio_m_oe = 1'b0;
   end

   // ****************************************************************
   // Bit cell: 5 cycles low then 5 high, keeping well below sys_clk/8
   // ****************************************************************
   task automatic bit_cell(input logic oe, input logic d, output logic s);
      @(negedge sys_clk);
      mdc = 1'b0;
      mdio_m_oe = oe;
      mdio_m = d;
      repeat (5) @(negedge sys_clk);
      s = mdio;                            // Sampled just ahead of the rising edge
      mdc = 1'b1;
      repeat (4) @(negedge sys_clk);
   endtask

   // Full frame: preamble, header, turnaround, 16 data bits, one idle cell
   task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd, output logic ta);
      logic [13:0] hdr;
      logic        s;
      logic        wr;
      hdr = {2'b01, op, pa, ra};
      wr = (op == PACSR_OP_WR);
      // No preamble suppression, so every frame carries the whole run of ones
      for (int i = 0; i < PACSR_PRE_LEN; i++) begin
         bit_cell(1'b1, 1'b1, s);
      end
      for (int i = 13; i >= 0; i--) begin
         bit_cell(1'b1, hdr[i], s);
      end
      bit_cell(wr, 1'b1, s);
      bit_cell(wr, 1'b0, ta);
      for (int i = 15; i >= 0; i--) begin
         bit_cell(wr, wd[i], s);
         rd[i] = s;
      end
      bit_cell(1'b0, 1'b1, s);
      mdc = 1'b0;
   endtask
endmodule

// [dv/phy_aux_control_status_reg_tb.sv]
// Self-checking bench for the auxiliary control and status register
`timescale 1ns/1ps
module phy_aux_control_status_reg_tb
   import pacsr_pkg::*;
;
   logic        sys_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        an_complete, an_enable, scr_lock, xover_det, cd_swap_det, res_duplex;
   logic [3:0]  pol_det;
   logic [1:0]  res_speed;
   logic        pair_swap_dis, pol_corr_dis, mii_soft_reset, mii_force_duplex;
   logic [2:0]  mii_speed_en;
   logic [4:0]  straps;
   logic [4:0]  phy_addr = 5'h05;
   logic        mdc, mdio_m, mdio_m_oe, mdio_o, mdio_oe;
   logic        swap_cd_en, mdix_internal, strap_override;
   logic        mode_aneg_disable, mode_force_duplex;
   logic [3:0]  pol_correct;
   logic [2:0]  mode_speed_en;
   wire         mdio;
   int          num_errors = 0;
   int          checked = 0;
   int          cycles = 0;

   // Shared data line with its pull-up
   assign mdio = mdio_oe ? mdio_o : (mdio_m_oe ? mdio_m : 1'b1);

   always #12.5 sys_clk = ~sys_clk;

   pacsr_aux_reg DUT (
      .sys_clk(sys_clk), .rst_b(rst_b), .mdc(mdc), .mdio_i(mdio), .mdio_o(mdio_o),
      .mdio_oe(mdio_oe), .phy_addr(phy_addr), .an_complete(an_complete),
      .an_enable(an_enable), .scr_lock(scr_lock), .xover_det(xover_det),
      .cd_swap_det(cd_swap_det), .pol_det(pol_det), .res_duplex(res_duplex),
      .res_speed(res_speed), .pair_swap_dis(pair_swap_dis), .pol_corr_dis(pol_corr_dis),
      .mii_soft_reset(mii_soft_reset), .mii_force_duplex(mii_force_duplex),
      .mii_speed_en(mii_speed_en), .strap_speed_low(straps[0]), .strap_speed_mid(straps[1]),
      .strap_speed_gig(straps[2]), .strap_force_duplex(straps[3]),
      .strap_negotiation_disable(straps[4]), .swap_cd_en(swap_cd_en),
      .pol_correct(pol_correct), .mdix_internal(mdix_internal),
      .strap_override(strap_override), .mode_aneg_disable(mode_aneg_disable),
      .mode_force_duplex(mode_force_duplex), .mode_speed_en(mode_speed_en));

   pacsr_smi_master U_MAC (
      .sys_clk(sys_clk), .mdc(mdc), .mdio_m(mdio_m), .mdio_m_oe(mdio_m_oe), .mdio(mdio));

   // ****************************************************************
   // Shared helpers
   // ****************************************************************
   task automatic finish_test();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Hang guard, sized at about twice the expected run
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         finish_test();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rd_chk(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] exp);
      logic [15:0] rd;
      logic        ta;
      U_MAC.frame(PACSR_OP_RD, pa, ra, 16'h0000, rd, ta);
      chk({15'h0, ta}, {15'h0, exp === 16'hffff});
      chk({15'h0, mdio_oe}, 16'h0000);
      chk(rd, exp);
   endtask

   task automatic wr(input logic [15:0] wd);
      logic [15:0] rd;
      logic        ta;
      U_MAC.frame(PACSR_OP_WR, phy_addr, PACSR_REG_ADDR, wd, rd, ta);
      repeat (4) @(negedge sys_clk);
   endtask

   // Status inputs: complete, enable, lock, crossover, swap, polarity, duplex, speed
   task automatic set_st(input logic [11:0] v);
      @(negedge sys_clk);
      {an_complete, an_enable, scr_lock, xover_det, cd_swap_det, pol_det, res_duplex,
       res_speed} = v;
      repeat (3) @(negedge sys_clk);
   endtask

   task automatic mode_chk(input logic [4:0] s, input logic [5:0] exp);
      straps = s;
      repeat (6) @(negedge sys_clk);
      chk({10'h0, strap_override, mode_aneg_disable, mode_force_duplex, mode_speed_en},
          {10'h0, exp});
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset();
      mode_chk(5'h00, 6'h20);
      rd_chk(phy_addr, PACSR_REG_ADDR, 16'h0000);
      rd_chk(phy_addr + 5'h1, PACSR_REG_ADDR, 16'hffff);
      rd_chk(phy_addr, 5'h1d, 16'hffff);
   endtask

   task automatic t_status();
      logic [15:0] want;
      for (int sp = 0; sp < 3; sp++) begin
         set_st({5'b10111, 4'ha, 1'b1, 2'(sp)});
         want = {3'b111, sp == 2, 4'ha, 3'b001, 2'(sp), 3'b000};
         rd_chk(phy_addr, PACSR_REG_ADDR, want);
      end
      chk({10'h0, swap_cd_en, pol_correct, mdix_internal}, 16'h0035);
      pair_swap_dis = 1'b1;
      pol_corr_dis = 1'b1;
      repeat (3) @(negedge sys_clk);
      chk({10'h0, swap_cd_en, pol_correct, mdix_internal}, 16'h0001);
      // Unlocked, 100 Mb/s, negotiation open: gated fields must read zero
      set_st({5'b01011, 4'h5, 1'b0, 2'h1});
      rd_chk(phy_addr, PACSR_REG_ADDR, 16'h0008);
      chk({15'h0, mdix_internal}, 16'h0000);
   endtask

   task automatic t_straps();
      mode_chk(5'h1c, 6'h3c);
      mode_chk(5'h1f, 6'h03);
      // Distinct strap levels expose a crossed strap to mode wiring, save a swap of the disable and gig straps
      mode_chk(5'h0a, 6'h2a);
      mode_chk(5'h1c, 6'h3c);
   endtask

   task automatic t_write();
      wr(16'hffff);
      rd_chk(phy_addr, PACSR_REG_ADDR, 16'h000e);
      mode_chk(5'h1c, 6'h03);
      // Register duplex setting must reach the mode while registers govern
      mii_force_duplex = 1'b1;
      mode_chk(5'h1c, 6'h0b);
   endtask

   task automatic t_soft();
      @(negedge sys_clk) mii_soft_reset = 1'b1;
      @(negedge sys_clk) mii_soft_reset = 1'b0;
      rd_chk(phy_addr, PACSR_REG_ADDR, 16'h000e);
      // Hardware reset in mid-run must drop both controls, sticky or not
      @(negedge sys_clk) rst_b = 1'b0;
      repeat (2) @(negedge sys_clk);
      rst_b = 1'b1;
      repeat (4) @(negedge sys_clk);
      rd_chk(phy_addr, PACSR_REG_ADDR, 16'h0008);
      wr(16'h0004);
      @(negedge sys_clk) mii_soft_reset = 1'b1;
      @(negedge sys_clk) mii_soft_reset = 1'b0;
      rd_chk(phy_addr, PACSR_REG_ADDR, 16'h0008);
      mode_chk(5'h1c, 6'h3c);
   endtask

   // Main sequence: reset first, then strap modes before priority is written
   initial begin
      {an_complete, an_enable, scr_lock, xover_det, cd_swap_det} = 5'b01000;
      pol_det = 4'h0;
      res_duplex = 1'b0;
      res_speed = 2'h0;
      {pair_swap_dis, pol_corr_dis, mii_soft_reset, mii_force_duplex} = 4'h0;
      mii_speed_en = 3'b011;
      straps = 5'h00;
      repeat (5) @(negedge sys_clk);
      rst_b = 1'b1;
      repeat (4) @(negedge sys_clk);
      t_reset();
      t_status();
      t_straps();
      t_write();
      t_soft();
      finish_test();
   end
endmodule
